// ==== hwtp_map.svh ====
`ifndef HWTP_MAP_SVH
`define HWTP_MAP_SVH
// Host byte bus addresses.
`define HWTP_ADDR_IN_LOW     20'hC0000
`define HWTP_ADDR_IN_MID     20'hC0001
`define HWTP_ADDR_IN_HIGH    20'hC0002
`define HWTP_ADDR_PEAK_LEFT  20'hC0003
`define HWTP_ADDR_PEAK_RIGHT 20'hC0004
`define HWTP_ADDR_SOFT_RST   20'hC0007
`define HWTP_ADDR_OUT_LOW    20'hC0010
`define HWTP_ADDR_OUT_MID    20'hC0011
`define HWTP_ADDR_OUT_HIGH   20'hC0012
`define HWTP_ADDR_PAIR0      20'hC0015
`define HWTP_ADDR_PAIR1      20'hC0016
`define HWTP_ADDR_PAIR2      20'hC0017
// Parallel bus addresses.
`define HWTP_PAR_MAIN_LEFT   5'h18
`define HWTP_PAR_MAIN_RIGHT  5'h19
`define HWTP_PAR_IN_LEFT     5'h1C
`define HWTP_PAR_IN_RIGHT    5'h1D
`define HWTP_PAR_TO_INBOX    5'h1E
`define HWTP_PAR_FROM_OUTBOX 5'h1F
// Field positions and reset values.
`define HWTP_SIGN_BIT        23
`define HWTP_PEAK_MSB        22
`define HWTP_PEAK_LSB        15
`define HWTP_PEAK_RESET      8'h00
`define HWTP_WORD_RESET      24'h000000
`endif

// ==== hwtp_pkg.sv ====
package hwtp_pkg;
    // Host byte bus request.
    typedef struct packed {
        logic [19:0] addr;
        logic [7:0]  wdata;
        logic        rd;
        logic        wr;
    } hwtp_host_req_t;
    // Parallel bus request as seen by the target.
    typedef struct packed {
        logic [4:0]  addr;
        logic [23:0] wdata;
        logic        read_n;
        logic        write_n;
    } hwtp_par_req_t;
    // Peak channel selector.
    typedef enum logic [1:0] {
        HWTP_CH_LEFT  = 2'b01,
        HWTP_CH_RIGHT = 2'b10
    } hwtp_chan_t;
endpackage

// ==== hwtp_top.sv ====
`timescale 1ns/10ps
`include "hwtp_map.svh"
// Summary of operation
// - Host writes three bytes into outbox word.
// - Bus read at 1F returns outbox word.
// - Bus write at 1E captures inbox word.
// - Host reads inbox word one byte each.
// - Host writes strobe three pair control loads.
// - Host read of reset address fires reset.
// - Two addresses return right and left peaks.
// - Compare only positive samples, sign clear.
// - Compared byte is word bits 22 to 15.
// - Larger positive byte replaces stored peak.
// - Peak read returns byte and clears hold.
// - Select low watches converter input reads.
// - Select high watches main output writes.
// - Bus has 24 data, 5 address, strobes.
// - Device never drives bus address or strobes.
module hwtp_top (
    // Clock, reset and enable.
    input  wire logic                    clk_sys,
    input  wire logic                    sys_rst,
    input  wire logic                    clk_en,
    // Host byte bus.
    input  wire hwtp_pkg::hwtp_host_req_t host_req,
    output logic [7:0]                   host_rdata,
    output logic                         host_rvalid,
    // Slave pair control strobes and data, and soft reset.
    output logic                         pair0_ctrl_write_n,
    output logic                         pair1_ctrl_write_n,
    output logic                         pair2_ctrl_write_n,
    output logic [7:0]                   pair_ctrl_data,
    output logic                         system_soft_reset_n,
    // Parallel bus target.
    input  wire hwtp_pkg::hwtp_par_req_t par_req,
    output logic [23:0]                  par_bus_data_out,
    output logic                         par_bus_data_oe_n,
    // Peak source and word clock.
    input  wire logic                    peak_source_select,
    input  wire logic                    sample_word_clock,
    output logic                         word_clock_seen
);
    import hwtp_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Host address decode.
    ////////////////////////////////////////////////////////////////////////////////

    // Matches one kind of host access at one address.
    function automatic logic host_hit(input hwtp_host_req_t req,
                                      input logic           want_rd,
                                      input logic [19:0]    at);
        return (want_rd ? req.rd : req.wr) && req.addr == at;
    endfunction

    // Each strobe is a decoded host access in the current cycle.
    wire hit_out_low   = host_hit(host_req, 1'b0, `HWTP_ADDR_OUT_LOW);
    wire hit_out_mid   = host_hit(host_req, 1'b0, `HWTP_ADDR_OUT_MID);
    wire hit_out_high  = host_hit(host_req, 1'b0, `HWTP_ADDR_OUT_HIGH);
    wire hit_pair0     = host_hit(host_req, 1'b0, `HWTP_ADDR_PAIR0);
    wire hit_pair1     = host_hit(host_req, 1'b0, `HWTP_ADDR_PAIR1);
    wire hit_pair2     = host_hit(host_req, 1'b0, `HWTP_ADDR_PAIR2);
    wire hit_in_low    = host_hit(host_req, 1'b1, `HWTP_ADDR_IN_LOW);
    wire hit_in_mid    = host_hit(host_req, 1'b1, `HWTP_ADDR_IN_MID);
    wire hit_in_high   = host_hit(host_req, 1'b1, `HWTP_ADDR_IN_HIGH);
    wire hit_peak_left = host_hit(host_req, 1'b1, `HWTP_ADDR_PEAK_LEFT);
    wire hit_peak_rght = host_hit(host_req, 1'b1, `HWTP_ADDR_PEAK_RIGHT);
    wire hit_soft_rst  = host_hit(host_req, 1'b1, `HWTP_ADDR_SOFT_RST);

    ////////////////////////////////////////////////////////////////////////////////
    // Parallel bus decode.
    ////////////////////////////////////////////////////////////////////////////////

    // Read and write strobes are active low; the device only listens to them.
    wire par_rd        = !par_req.read_n;
    wire par_wr        = !par_req.write_n;
    wire outbox_to_bus = par_rd && par_req.addr == `HWTP_PAR_FROM_OUTBOX;
    wire bus_to_inbox  = par_wr && par_req.addr == `HWTP_PAR_TO_INBOX;
    wire left_in_rd    = par_rd && par_req.addr == `HWTP_PAR_IN_LEFT;
    wire right_in_rd   = par_rd && par_req.addr == `HWTP_PAR_IN_RIGHT;
    wire left_main_wr  = par_wr && par_req.addr == `HWTP_PAR_MAIN_LEFT;
    wire right_main_wr = par_wr && par_req.addr == `HWTP_PAR_MAIN_RIGHT;

    // Source select picks input reads or main output writes.
    wire mon_left  = peak_source_select ? left_main_wr  : left_in_rd;
    wire mon_right = peak_source_select ? right_main_wr : right_in_rd;

    // Positive samples only; the compared byte sits below the sign bit.
    wire       sample_pos  = !par_req.wdata[`HWTP_SIGN_BIT];
    wire [7:0] sample_byte = par_req.wdata[`HWTP_PEAK_MSB:`HWTP_PEAK_LSB];

    ////////////////////////////////////////////////////////////////////////////////
    // Storage.
    ////////////////////////////////////////////////////////////////////////////////

    logic [23:0] outbox_q;
    logic [23:0] inbox_q;
    logic [7:0]  peak_left_q;
    logic [7:0]  peak_right_q;
    logic        soft_rst_q;
    logic        wc_meta_q;
    logic        wc_sync_q;

    // Peak update decision, shared by both channels.
    // A larger sample in the cycle of a read clear wins, so no peak is lost.
    function automatic logic [7:0] peak_next(input logic [7:0] held,
                                             input logic       watch,
                                             input logic       clear);
        logic [7:0] r;
        r = held;
        if (watch && sample_pos && sample_byte > held) begin
            r = sample_byte;
        end else if (clear) begin
            r = `HWTP_PEAK_RESET;
        end
        return r;
    endfunction

    wire [7:0] peak_left_d  = peak_next(peak_left_q, mon_left, hit_peak_left);
    wire [7:0] peak_right_d = peak_next(peak_right_q, mon_right, hit_peak_rght);

    // Read data selection; unmapped reads and the soft reset read return zero.
    wire [7:0] host_rdata_d = hit_in_low    ? inbox_q[7:0]   :
                              hit_in_mid    ? inbox_q[15:8]  :
                              hit_in_high   ? inbox_q[23:16] :
                              hit_peak_left ? peak_left_q    :
                              hit_peak_rght ? peak_right_q   :
                              8'h00;

    // Outbox bytes from the host, inbox word from the bus.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            outbox_q <= `HWTP_WORD_RESET;
            inbox_q  <= `HWTP_WORD_RESET;
        end else if (clk_en) begin
            if (hit_out_low)  outbox_q[7:0]   <= host_req.wdata;
            if (hit_out_mid)  outbox_q[15:8]  <= host_req.wdata;
            if (hit_out_high) outbox_q[23:16] <= host_req.wdata;
            if (bus_to_inbox) inbox_q <= par_req.wdata;
        end
    end

    // Peak holds; a soft reset also zeroes them.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            peak_left_q  <= `HWTP_PEAK_RESET;
            peak_right_q <= `HWTP_PEAK_RESET;
        end else if (clk_en) begin
            if (soft_rst_q) begin
                peak_left_q  <= `HWTP_PEAK_RESET;
                peak_right_q <= `HWTP_PEAK_RESET;
            end else begin
                peak_left_q  <= peak_left_d;
                peak_right_q <= peak_right_d;
            end
        end
    end

    // Host read data, strobes and soft reset pulse, all registered.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            host_rdata          <= 8'h00;
            host_rvalid         <= 1'b0;
            pair0_ctrl_write_n  <= 1'b1;
            pair1_ctrl_write_n  <= 1'b1;
            pair2_ctrl_write_n  <= 1'b1;
            pair_ctrl_data      <= 8'h00;
            soft_rst_q          <= 1'b0;
        end else if (clk_en) begin
            host_rvalid        <= host_req.rd && !hit_soft_rst;
            soft_rst_q         <= hit_soft_rst;
            pair0_ctrl_write_n <= !hit_pair0;
            pair1_ctrl_write_n <= !hit_pair1;
            pair2_ctrl_write_n <= !hit_pair2;
            if (host_req.wr) pair_ctrl_data <= host_req.wdata;
            if (host_req.rd) host_rdata <= host_rdata_d;
        end
    end

    // The pulse lasts one cycle and leaves both transfer registers untouched.
    assign system_soft_reset_n = !soft_rst_q;

    // Outbox drive onto the bus, registered; enable low while driving.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            par_bus_data_out  <= `HWTP_WORD_RESET;
            par_bus_data_oe_n <= 1'b1;
        end else if (clk_en) begin
            par_bus_data_out  <= outbox_q;
            par_bus_data_oe_n <= !outbox_to_bus;
        end
    end

    // Word clock synchroniser for host polling.
    // Two stages keep the polled value two clean samples behind the pin.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            wc_meta_q <= 1'b0;
            wc_sync_q <= 1'b0;
        end else if (clk_en) begin
            wc_meta_q <= sample_word_clock;
            wc_sync_q <= wc_meta_q;
        end
    end
    assign word_clock_seen = wc_sync_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions.
    ////////////////////////////////////////////////////////////////////////////////

    a_outbox_low_load: assert property (@(posedge clk_sys) disable iff (sys_rst)
        clk_en && hit_out_low |=> outbox_q[7:0] == $past(host_req.wdata))
        else $error("outbox low byte not loaded");
    a_outbox_drive: assert property (@(posedge clk_sys) disable iff (sys_rst)
        clk_en && outbox_to_bus |=> !par_bus_data_oe_n && par_bus_data_out == $past(outbox_q))
        else $error("outbox not driven on bus read");
    a_inbox_capture: assert property (@(posedge clk_sys) disable iff (sys_rst)
        clk_en && bus_to_inbox |=> inbox_q == $past(par_req.wdata))
        else $error("inbox word not captured");
    a_inbox_high_read: assert property (@(posedge clk_sys) disable iff (sys_rst)
        clk_en && hit_in_high |=> host_rvalid && host_rdata == $past(inbox_q[23:16]))
        else $error("inbox high byte wrong");
    a_pair_strobe: assert property (@(posedge clk_sys) disable iff (sys_rst)
        clk_en && hit_pair1 |=> !pair1_ctrl_write_n && pair0_ctrl_write_n)
        else $error("pair one strobe wrong");
    a_soft_reset_pulse: assert property (@(posedge clk_sys) disable iff (sys_rst)
        clk_en && hit_soft_rst |=> !system_soft_reset_n && !host_rvalid)
        else $error("soft reset not generated");
    a_peak_negative: assert property (@(posedge clk_sys) disable iff (sys_rst)
        clk_en && !sample_pos && !hit_peak_left && !soft_rst_q
        |=> peak_left_q == $past(peak_left_q))
        else $error("negative sample changed peak");
    a_peak_rise: assert property (@(posedge clk_sys) disable iff (sys_rst)
        clk_en && mon_right && sample_pos && !soft_rst_q
        && par_req.wdata[22:15] > peak_right_q |=> peak_right_q == $past(par_req.wdata[22:15]))
        else $error("right peak not raised");
    a_peak_clear: assert property (@(posedge clk_sys) disable iff (sys_rst)
        clk_en && hit_peak_left && !mon_left |=> peak_left_q == 8'h00
        && host_rdata == $past(peak_left_q))
        else $error("left peak read or clear wrong");
    a_select_high: assert property (@(posedge clk_sys) disable iff (sys_rst)
        clk_en && peak_source_select && !right_main_wr && !hit_peak_rght && !soft_rst_q
        |=> peak_right_q == $past(peak_right_q))
        else $error("right peak moved without a main output write");

    // Transfer register and host read checks; all read state one cycle late.
    a_outbox_mid_load: assert property (@(posedge clk_sys) disable iff (sys_rst)
        clk_en && hit_out_mid |=> outbox_q[15:8] == $past(host_req.wdata))
        else $error("outbox middle byte not loaded");
    a_outbox_high_load: assert property (@(posedge clk_sys) disable iff (sys_rst)
        clk_en && hit_out_high |=> outbox_q[23:16] == $past(host_req.wdata))
        else $error("outbox high byte not loaded");
    a_outbox_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
        clk_en && !host_req.wr |=> outbox_q == $past(outbox_q))
        else $error("outbox changed without a host write");
    a_drive_idle: assert property (@(posedge clk_sys) disable iff (sys_rst)
        clk_en && !outbox_to_bus |=> par_bus_data_oe_n)
        else $error("bus driven without an outbox read");
    a_drive_data: assert property (@(posedge clk_sys) disable iff (sys_rst)
        clk_en |=> par_bus_data_out == $past(outbox_q))
        else $error("bus data differs from outbox");
    a_inbox_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
        clk_en && !bus_to_inbox |=> inbox_q == $past(inbox_q))
        else $error("inbox changed without a bus write");
    a_inbox_mid_read: assert property (@(posedge clk_sys) disable iff (sys_rst)
        clk_en && hit_in_mid |=> host_rvalid && host_rdata == $past(inbox_q[15:8]))
        else $error("inbox middle byte wrong");
    a_inbox_low_read: assert property (@(posedge clk_sys) disable iff (sys_rst)
        clk_en && hit_in_low |=> host_rvalid && host_rdata == $past(inbox_q[7:0]))
        else $error("inbox low byte wrong");
    a_read_valid: assert property (@(posedge clk_sys) disable iff (sys_rst)
        clk_en && !host_req.rd |=> !host_rvalid)
        else $error("read valid without a read");
    a_in_read_valid: assert property (@(posedge clk_sys) disable iff (sys_rst)
        clk_en && host_req.rd && !hit_soft_rst |=> host_rvalid)
        else $error("read valid missing");
    a_rdata_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
        clk_en && !host_req.rd |=> host_rdata == $past(host_rdata))
        else $error("read data changed without a read");
    a_unmapped_read_zero: assert property (@(posedge clk_sys) disable iff (sys_rst)
        clk_en && host_req.rd && !hit_in_low && !hit_in_mid && !hit_in_high
        && !hit_peak_left && !hit_peak_rght |=> host_rdata == 8'h00)
        else $error("unmapped read not zero");

    // Strobe and soft reset checks.
    a_pair0_strobe: assert property (@(posedge clk_sys) disable iff (sys_rst)
        clk_en && hit_pair0 |=> !pair0_ctrl_write_n && pair1_ctrl_write_n
        && pair2_ctrl_write_n && pair_ctrl_data == $past(host_req.wdata))
        else $error("pair zero strobe wrong");
    a_pair2_strobe: assert property (@(posedge clk_sys) disable iff (sys_rst)
        clk_en && hit_pair2 |=> !pair2_ctrl_write_n
        && pair0_ctrl_write_n && pair1_ctrl_write_n)
        else $error("pair two strobe wrong");
    a_pair_idle: assert property (@(posedge clk_sys) disable iff (sys_rst)
        clk_en && !hit_pair0 && !hit_pair1 && !hit_pair2
        |=> pair0_ctrl_write_n && pair1_ctrl_write_n && pair2_ctrl_write_n)
        else $error("pair strobe without its write");
    a_soft_reset_idle: assert property (@(posedge clk_sys) disable iff (sys_rst)
        clk_en && !hit_soft_rst |=> system_soft_reset_n)
        else $error("soft reset without its read");
    a_soft_reset_zero: assert property (@(posedge clk_sys) disable iff (sys_rst)
        clk_en && soft_rst_q
        |=> peak_left_q == 8'h00 && peak_right_q == 8'h00)
        else $error("soft reset left a peak");

    // Peak detector and word clock checks.
    a_peak_right_clear: assert property (@(posedge clk_sys) disable iff (sys_rst)
        clk_en && hit_peak_rght && !mon_right |=> peak_right_q == 8'h00
        && host_rdata == $past(peak_right_q))
        else $error("right peak read or clear wrong");
    a_peak_left_rise: assert property (@(posedge clk_sys) disable iff (sys_rst)
        clk_en && mon_left && sample_pos && !soft_rst_q
        && par_req.wdata[22:15] > peak_left_q |=> peak_left_q == $past(par_req.wdata[22:15]))
        else $error("left peak not raised");
    a_peak_keep_small: assert property (@(posedge clk_sys) disable iff (sys_rst)
        clk_en && mon_left && sample_byte <= peak_left_q && !hit_peak_left && !soft_rst_q
        |=> peak_left_q == $past(peak_left_q))
        else $error("left peak moved on a smaller sample");
    a_peak_right_small: assert property (@(posedge clk_sys) disable iff (sys_rst)
        clk_en && mon_right && sample_byte <= peak_right_q && !hit_peak_rght && !soft_rst_q
        |=> peak_right_q == $past(peak_right_q))
        else $error("right peak moved on a smaller sample");
    a_peak_right_neg: assert property (@(posedge clk_sys) disable iff (sys_rst)
        clk_en && !sample_pos && !hit_peak_rght && !soft_rst_q
        |=> peak_right_q == $past(peak_right_q))
        else $error("negative sample changed right peak");
    a_select_low: assert property (@(posedge clk_sys) disable iff (sys_rst)
        clk_en && !peak_source_select && !left_in_rd && !hit_peak_left && !soft_rst_q
        |=> peak_left_q == $past(peak_left_q))
        else $error("left peak moved without an input read");
    a_right_select_low: assert property (@(posedge clk_sys) disable iff (sys_rst)
        clk_en && !peak_source_select && !right_in_rd && !hit_peak_rght && !soft_rst_q
        |=> peak_right_q == $past(peak_right_q))
        else $error("right peak moved without an input read");
    a_left_select_high: assert property (@(posedge clk_sys) disable iff (sys_rst)
        clk_en && peak_source_select && !left_main_wr && !hit_peak_left && !soft_rst_q
        |=> peak_left_q == $past(peak_left_q))
        else $error("left peak moved without a main output write");
    a_word_clock_sync: assert property (@(posedge clk_sys) disable iff (sys_rst)
        clk_en ##1 clk_en |=> word_clock_seen == $past(sample_word_clock, 2))
        else $error("word clock not passed through");
endmodule

// ==== hwtp_par_master.sv ====
`timescale 1ns/10ps
module hwtp_par_master (
    // Bench clock.
    input  wire logic              clk_sys,
    // Bus toward the target.
    output hwtp_pkg::hwtp_par_req_t par_req
);
    import hwtp_pkg::*;
    ////////////////////////////////////////////////////////////
    // The bus starts idle with both strobes high.
    initial begin
        par_req = '0;
        par_req.read_n = 1'b1;
        par_req.write_n = 1'b1;
    end
    // One transfer after an optional stall, held across one rising edge.
    // Released address and data lines show the inverse of the last value so that stale data cannot match.
    task automatic xfer(input logic [4:0] a, input logic [23:0] d, input logic rd, input int gap);
        repeat (gap) @(negedge clk_sys);
        @(negedge clk_sys);
        par_req.addr = a;
        par_req.wdata = d;
        par_req.read_n = ~rd;
        par_req.write_n = rd;
        @(negedge clk_sys);
        par_req.read_n = 1'b1;
        par_req.write_n = 1'b1;
        par_req.addr = ~a;
        par_req.wdata = ~d;
    endtask
endmodule

// ==== testbench.sv ====
`timescale 1ns/10ps
`include "hwtp_map.svh"
module testbench;
    import hwtp_pkg::*;
    logic           clk_sys = 1'b0;
    logic           sys_rst, clk_en, peak_source_select, sample_word_clock;
    hwtp_host_req_t host_req;
    hwtp_par_req_t  par_req;
    logic [7:0]     host_rdata, pair_ctrl_data, d, exp_l, exp_r;
    logic           host_rvalid, system_soft_reset_n, par_bus_data_oe_n, word_clock_seen;
    logic           pair0_ctrl_write_n, pair1_ctrl_write_n, pair2_ctrl_write_n, mon;
    logic [23:0]    par_bus_data_out, w, v;
    logic [31:0]    r;
    logic [2:0]     s;
    integer         seed;
    int             n_fail = 0;
    int             comparisons = 0;
    wire  [2:0]     strobes_n = {pair2_ctrl_write_n, pair1_ctrl_write_n, pair0_ctrl_write_n};
    ////////////////////////////////////////////////////////////
    // Clock at 100 MHz.
    always #5 clk_sys = ~clk_sys;
    hwtp_top u_hwtp_top (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en),
        .host_req(host_req), .host_rdata(host_rdata), .host_rvalid(host_rvalid),
        .pair0_ctrl_write_n(pair0_ctrl_write_n), .pair1_ctrl_write_n(pair1_ctrl_write_n),
        .pair2_ctrl_write_n(pair2_ctrl_write_n), .pair_ctrl_data(pair_ctrl_data),
        .system_soft_reset_n(system_soft_reset_n), .par_req(par_req),
        .par_bus_data_out(par_bus_data_out), .par_bus_data_oe_n(par_bus_data_oe_n),
        .peak_source_select(peak_source_select), .sample_word_clock(sample_word_clock),
        .word_clock_seen(word_clock_seen));
    hwtp_par_master u_hwtp_par_master (.clk_sys(clk_sys), .par_req(par_req));
    ////////////////////////////////////////////////////////////
    // Expected held peak after one monitored word.
    function automatic logic [7:0] peak_next(input logic [7:0] held, input logic [23:0] x);
        return (!x[23] && x[22:15] > held) ? x[22:15] : held;
    endfunction
    // Compares and counts.
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One host access held across one rising edge; outputs are settled on return.
    task automatic host_op(input logic [19:0] a, input logic [7:0] dat, input logic rd);
        @(negedge clk_sys);
        host_req = '{addr: a, wdata: dat, rd: rd, wr: ~rd};
        @(negedge clk_sys);
        host_req = '{addr: ~a, wdata: ~dat, rd: 1'b0, wr: 1'b0};
    endtask
    // Host read with its expected byte and valid pulse.
    task automatic rd_chk(input logic [19:0] a, input logic [7:0] exp);
        host_op(a, 8'h00, 1'b1);
        check({15'h0000, host_rvalid, host_rdata}, {16'h0001, exp});
    endtask
    // Prints the verdict and ends the run.
    task automatic stop_test;
        if (n_fail == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    // Watchdog against a hang.
    initial begin
        #200000;
        n_fail++;
        stop_test();
    end
    // Main sequence.
    initial begin
        seed = 32'h054F;
        host_req = '0;
        clk_en = 1'b1;
        peak_source_select = 1'b0;
        sample_word_clock = 1'b0;
        sys_rst = 1'b1;
        repeat (5) @(negedge clk_sys);
        sys_rst = 1'b0;
        rd_chk(`HWTP_ADDR_PEAK_LEFT, 8'h00);
        rd_chk(`HWTP_ADDR_PEAK_RIGHT, 8'h00);
        w = 24'($random(seed));
        host_op(`HWTP_ADDR_OUT_LOW, w[7:0], 1'b0);
        host_op(`HWTP_ADDR_OUT_MID, w[15:8], 1'b0);
        host_op(`HWTP_ADDR_OUT_HIGH, w[23:16], 1'b0);
        u_hwtp_par_master.xfer(5'h1F, 24'h000000, 1'b1, 0);
        check({par_bus_data_oe_n, par_bus_data_out[22:0]}, {1'b0, w[22:0]});
        check(par_bus_data_out, w);
        @(negedge clk_sys);
        check({23'h000000, par_bus_data_oe_n}, 24'h000001);
        v = 24'($random(seed));
        u_hwtp_par_master.xfer(5'h1E, v, 1'b0, 1);
        rd_chk(`HWTP_ADDR_IN_HIGH, v[23:16]);
        rd_chk(`HWTP_ADDR_IN_MID, v[15:8]);
        clk_en = 1'b0;
        u_hwtp_par_master.xfer(5'h1E, ~v, 1'b0, 0);
        clk_en = 1'b1;
        rd_chk(`HWTP_ADDR_IN_LOW, v[7:0]);
        rd_chk(20'hC0005, 8'h00);
        // Unused address first, then each pair strobe alone.
        for (int i = 0; i < 4; i++) begin
            d = 8'($random(seed));
            s = (i == 0) ? 3'b111 : ~(3'b001 << (i - 1));
            host_op(20'hC0014 + 20'(i), d, 1'b0);
            check({21'h000000, strobes_n}, {21'h000000, s});
            if (i > 0) check({16'h0000, pair_ctrl_data}, {16'h0000, d});
        end
        u_hwtp_par_master.xfer(`HWTP_PAR_IN_LEFT, 24'h7F8000, 1'b1, 0);
        host_op(`HWTP_ADDR_SOFT_RST, 8'h00, 1'b1);
        check({22'h000000, system_soft_reset_n, host_rvalid}, 24'h000000);
        rd_chk(`HWTP_ADDR_PEAK_LEFT, 8'h00);
        // A watched word and a peak read in one cycle: the new peak survives.
        fork
            rd_chk(`HWTP_ADDR_PEAK_LEFT, 8'h00);
            u_hwtp_par_master.xfer(`HWTP_PAR_IN_LEFT, 24'h3F8000, 1'b1, 0);
        join
        rd_chk(`HWTP_ADDR_PEAK_LEFT, 8'h7F);
        exp_l = 8'h00;
        exp_r = 8'h00;
        // Random traffic on watched and unwatched places, both source selections.
        for (int sel = 0; sel < 2; sel++) begin
            peak_source_select = sel[0];
            for (int k = 0; k < 80; k++) begin
                r = $random(seed);
                w = 24'($random(seed));
                if (r[27]) w[23] = 1'b0;
                if (r[30]) w[22:15] = r[24] ? exp_r : exp_l;
                mon = sel[0] ? (!r[26] && !r[25]) : (r[26] && r[25]);
                u_hwtp_par_master.xfer({2'b11, r[25], 1'b0, r[24]}, w, r[26], int'(r[29:28]));
                if (mon && r[24]) exp_r = peak_next(exp_r, w);
                if (mon && !r[24]) exp_l = peak_next(exp_l, w);
                // Reading every eighth transfer sets the measuring period.
                if (k % 8 == 7) begin
                    rd_chk(`HWTP_ADDR_PEAK_LEFT, exp_l);
                    rd_chk(`HWTP_ADDR_PEAK_RIGHT, exp_r);
                    exp_l = 8'h00;
                    exp_r = 8'h00;
                end
            end
        end
        rd_chk(`HWTP_ADDR_PEAK_LEFT, 8'h00);
        check({23'h000000, word_clock_seen}, 24'h000000);
        sample_word_clock = 1'b1;
        repeat (3) @(negedge clk_sys);
        check({23'h000000, word_clock_seen}, 24'h000001);
        stop_test();
    end
endmodule
